//--- tlic_top.sv
// What this block does
// - Six sources, each enabled, two levels
// - Display blanking start raises busy request
// - Text mode: each active line's horizontal blanking
// - Vertical mode: once per field, vertical blanking
// - Per-source enable bit blocks or allows
// - Global enable bit seven blocks all requests; status and irqLine unaffected
// - Priority bit sets level; high preempts low
// - Nothing preempts a high-level routine
// - Simultaneous: high level served first
// - Equal level: fixed polling order
// - Vectors 0003, 000B, 0013 by hardware call
// - Vectors 001B, 002B, 0033 for rest
// - Sense bit zero: pin low requests
// - Sense one: pin0 falling, pin1 both edges
// - Enabled request clears idle bit
`timescale 1ns/100ps
`default_nettype none
`include "tlic_defines.svh"

module tlic_top
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [`TLIC_ADDR_W-1:0] regAddr,
    input wire logic [`TLIC_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [`TLIC_DATA_W-1:0] regRdata,
    // External pins
    input wire logic extPin0,
    input wire logic extPin1,
    // On-chip sources
    input wire logic tmrOvf0,
    input wire logic tmrOvf1,
    input wire logic serialBusEvt,
    input wire logic hBlank,
    input wire logic vBlank,
    input wire logic lineActive,
    // Core handshake
    output logic irqReq,
    output logic [`TLIC_VEC_W-1:0] irqVector,
    input wire logic irqAck,
    input wire logic irqReturn,
    // Power and event line
    output logic idleMode,
    output logic irqLine
);

    tlic_state_t stateFf;
    tlic_state_t nxt_state;
    tlic_bus_t bus;

    logic ext0Level;
    logic ext0Edge;
    logic ext1Level;
    logic ext1Edge;
    logic blankEvt;

    // Lowest index wins within a level
    function automatic logic [`TLIC_SRC_W-1:0] pickFirst(input logic [`TLIC_NSRC-1:0] req);
        logic [`TLIC_SRC_W-1:0] idx;
        idx = '0;
        for (int i = `TLIC_NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = i[`TLIC_SRC_W-1:0];
            end
        end
        return idx;
    endfunction : pickFirst

    function automatic logic [`TLIC_VEC_W-1:0] vecOf(input logic [`TLIC_SRC_W-1:0] src);
        logic [`TLIC_VEC_W-1:0] v;
        case (src)
            `TLIC_SRC_EXT0: v = `TLIC_VEC_EXT0;
            `TLIC_SRC_TMR0: v = `TLIC_VEC_TMR0;
            `TLIC_SRC_EXT1: v = `TLIC_VEC_EXT1;
            `TLIC_SRC_TMR1: v = `TLIC_VEC_TMR1;
            `TLIC_SRC_SER: v = `TLIC_VEC_SER;
            `TLIC_SRC_BLANK: v = `TLIC_VEC_BLANK;
            default: v = `TLIC_RST_VEC;
        endcase
        return v;
    endfunction : vecOf

    function automatic logic [`TLIC_DATA_W-1:0] pad8(input logic [`TLIC_NSRC-1:0] val);
        return {{(`TLIC_DATA_W - `TLIC_NSRC){1'b0}}, val};
    endfunction : pad8

    tlic_ext_sense #(
        .BOTH_EDGES(1'b0)
    ) u_ext0 (
        .clk(clk),
        .rst(rst),
        .pinAsync(extPin0),
        .senseEdge(stateFf.sense0),
        .levelReq(ext0Level),
        .edgeEvt(ext0Edge)
    );

    tlic_ext_sense #(
        .BOTH_EDGES(1'b1)
    ) u_ext1 (
        .clk(clk),
        .rst(rst),
        .pinAsync(extPin1),
        .senseEdge(stateFf.sense1),
        .levelReq(ext1Level),
        .edgeEvt(ext1Edge)
    );

    tlic_blank_det u_blank (
        .clk(clk),
        .rst(rst),
        .hBlank(hBlank),
        .vBlank(vBlank),
        .lineActive(lineActive),
        .textMode(stateFf.textMode),
        .blankEvt(blankEvt)
    );

    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    always_comb begin
        logic [`TLIC_NSRC-1:0] evtSet;
        logic [`TLIC_NSRC-1:0] pendClr;
        logic [`TLIC_NSRC-1:0] rawReq;
        logic [`TLIC_NSRC-1:0] enabled;
        logic [`TLIC_NSRC-1:0] hiReq;
        logic [`TLIC_NSRC-1:0] loReq;
        logic [`TLIC_NSRC-1:0] w1c;
        logic ackTaken;
        logic ackLevel;
        evtSet = '0;
        pendClr = '0;
        rawReq = '0;
        enabled = '0;
        hiReq = '0;
        loReq = '0;
        w1c = '0;
        ackTaken = 1'b0;
        ackLevel = 1'b0;
        nxt_state = stateFf;
        nxt_state.rdata = `TLIC_RST_BYTE;

        // Event capture: edge events and on-chip pulses latch as pending
        evtSet[`TLIC_SRC_EXT0] = ext0Edge;
        evtSet[`TLIC_SRC_TMR0] = tmrOvf0;
        evtSet[`TLIC_SRC_EXT1] = ext1Edge;
        evtSet[`TLIC_SRC_TMR1] = tmrOvf1;
        evtSet[`TLIC_SRC_SER] = serialBusEvt;
        evtSet[`TLIC_SRC_BLANK] = blankEvt;

        // Core takes the offered vector
        ackTaken = (stateFf.phase == TLIC_ST_OFFER) && irqAck;
        if (ackTaken) begin
            pendClr[stateFf.src] = 1'b1;
            ackLevel = stateFf.ip[stateFf.src];
            if (ackLevel) begin
                nxt_state.inSvcHigh = 1'b1;
            end else begin
                nxt_state.inSvcLow = 1'b1;
            end
        end

        // Return unwinds the innermost active level
        if (irqReturn) begin
            if (stateFf.inSvcHigh) begin
                nxt_state.inSvcHigh = 1'b0;
            end else begin
                nxt_state.inSvcLow = 1'b0;
            end
        end

        // A new event beats the acknowledge clear
        nxt_state.pend = (stateFf.pend & ~pendClr) | evtSet;

        // Level mode pins request while low, with nothing latched
        rawReq = nxt_state.pend;
        rawReq[`TLIC_SRC_EXT0] = stateFf.sense0 ? nxt_state.pend[`TLIC_SRC_EXT0] : ext0Level;
        rawReq[`TLIC_SRC_EXT1] = stateFf.sense1 ? nxt_state.pend[`TLIC_SRC_EXT1] : ext1Level;

        enabled = rawReq & stateFf.ie[`TLIC_NSRC-1:0] & {`TLIC_NSRC{stateFf.ie[`TLIC_IE_GLOBAL_BIT]}};
        hiReq = enabled & stateFf.ip;
        loReq = enabled & ~stateFf.ip;

        // Enabled request wakes the core
        if (|enabled) begin
            nxt_state.idle = 1'b0;
        end

        // Arbitration
        case (stateFf.phase)
            TLIC_ST_IDLE, TLIC_ST_OFFER: begin
                if (ackTaken) begin
                    nxt_state.phase = TLIC_ST_ACKED;
                end else if (|hiReq && !nxt_state.inSvcHigh) begin
                    nxt_state.phase = TLIC_ST_OFFER;
                    nxt_state.src = pickFirst(hiReq);
                    nxt_state.vec = vecOf(pickFirst(hiReq));
                end else if (|loReq && !nxt_state.inSvcHigh && !nxt_state.inSvcLow) begin
                    nxt_state.phase = TLIC_ST_OFFER;
                    nxt_state.src = pickFirst(loReq);
                    nxt_state.vec = vecOf(pickFirst(loReq));
                end else begin
                    nxt_state.phase = TLIC_ST_IDLE;
                end
            end
            TLIC_ST_ACKED: begin
                // Two quiet cycles (ACKED, then IDLE) let the routine start before a new offer
                nxt_state.phase = TLIC_ST_IDLE;
            end
            default: begin
                nxt_state.phase = TLIC_ST_IDLE;
            end
        endcase

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                `TLIC_ADDR_IE: begin
                    nxt_state.ie = bus.wdata;
                end
                `TLIC_ADDR_IP: begin
                    nxt_state.ip = bus.wdata[`TLIC_NSRC-1:0];
                end
                `TLIC_ADDR_TCTL: begin
                    nxt_state.sense0 = bus.wdata[`TLIC_TCTL_SENSE0_BIT];
                    nxt_state.sense1 = bus.wdata[`TLIC_TCTL_SENSE1_BIT];
                end
                `TLIC_ADDR_STATUS: begin
                    w1c = bus.wdata[`TLIC_NSRC-1:0];
                end
                `TLIC_ADDR_MASK: begin
                    nxt_state.mask = bus.wdata[`TLIC_NSRC-1:0];
                end
                `TLIC_ADDR_IDLE: begin
                    // Hardware wake has priority over software entering idle
                    nxt_state.idle = bus.wdata[`TLIC_IDLE_BIT] && !(|enabled);
                end
                `TLIC_ADDR_CFG: begin
                    nxt_state.textMode = bus.wdata[`TLIC_CFG_TEXT_BIT];
                end
                default: begin
                end
            endcase
        end

        // Sticky status: set wins over write-one-to-clear
        nxt_state.status = (stateFf.status & ~w1c) | evtSet;

        // Register reads, data valid the following cycle only
        if (bus.rd) begin
            case (bus.addr)
                `TLIC_ADDR_IE: begin
                    nxt_state.rdata = stateFf.ie;
                end
                `TLIC_ADDR_IP: begin
                    nxt_state.rdata = pad8(stateFf.ip);
                end
                `TLIC_ADDR_TCTL: begin
                    nxt_state.rdata[`TLIC_TCTL_SENSE0_BIT] = stateFf.sense0;
                    nxt_state.rdata[`TLIC_TCTL_SENSE1_BIT] = stateFf.sense1;
                end
                `TLIC_ADDR_STATUS: begin
                    nxt_state.rdata = pad8(stateFf.status);
                end
                `TLIC_ADDR_MASK: begin
                    nxt_state.rdata = pad8(stateFf.mask);
                end
                `TLIC_ADDR_IDLE: begin
                    nxt_state.rdata[`TLIC_IDLE_BIT] = stateFf.idle;
                end
                `TLIC_ADDR_LEVEL: begin
                    nxt_state.rdata[`TLIC_LEVEL_LOW_BIT] = stateFf.inSvcLow;
                    nxt_state.rdata[`TLIC_LEVEL_HIGH_BIT] = stateFf.inSvcHigh;
                    nxt_state.rdata[`TLIC_LEVEL_REQ_BIT] = stateFf.phase == TLIC_ST_OFFER;
                end
                `TLIC_ADDR_VECLO: begin
                    nxt_state.rdata = stateFf.vec[`TLIC_DATA_W-1:0];
                end
                `TLIC_ADDR_CFG: begin
                    nxt_state.rdata[`TLIC_CFG_TEXT_BIT] = stateFf.textMode;
                end
                default: begin
                    nxt_state.rdata = `TLIC_RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateFf <= '{
                ie: `TLIC_RST_BYTE,
                ip: `TLIC_RST_SRC,
                sense0: 1'b0,
                sense1: 1'b0,
                textMode: 1'b0,
                idle: 1'b0,
                status: `TLIC_RST_SRC,
                mask: `TLIC_RST_SRC,
                pend: `TLIC_RST_SRC,
                inSvcLow: 1'b0,
                inSvcHigh: 1'b0,
                phase: TLIC_ST_IDLE,
                src: '0,
                vec: `TLIC_RST_VEC,
                rdata: `TLIC_RST_BYTE
            };
        end else begin
            stateFf <= nxt_state;
        end
    end

    assign regRdata = stateFf.rdata;
    assign irqReq = stateFf.phase == TLIC_ST_OFFER;
    assign irqVector = stateFf.vec;
    assign idleMode = stateFf.idle;
    assign irqLine = |(stateFf.status & stateFf.mask);

endmodule : tlic_top

`default_nettype wire

//--- tlic_defines.svh
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

// Register addresses
`define TLIC_ADDR_W 16
`define TLIC_DATA_W 8
`define TLIC_ADDR_IE 16'h0000
`define TLIC_ADDR_IP 16'h0001
`define TLIC_ADDR_TCTL 16'h0002
`define TLIC_ADDR_STATUS 16'h0003
`define TLIC_ADDR_MASK 16'h0004
`define TLIC_ADDR_IDLE 16'h0005
`define TLIC_ADDR_LEVEL 16'h0006
`define TLIC_ADDR_VECLO 16'h0007
`define TLIC_ADDR_CFG 16'h87ff

// Source count and field positions
`define TLIC_NSRC 6
`define TLIC_SRC_W 3
`define TLIC_SRC_EXT0 3'h0
`define TLIC_SRC_TMR0 3'h1
`define TLIC_SRC_EXT1 3'h2
`define TLIC_SRC_TMR1 3'h3
`define TLIC_SRC_SER 3'h4
`define TLIC_SRC_BLANK 3'h5
`define TLIC_IE_GLOBAL_BIT 7
`define TLIC_TCTL_SENSE0_BIT 0
`define TLIC_TCTL_SENSE1_BIT 1
`define TLIC_CFG_TEXT_BIT 0
`define TLIC_IDLE_BIT 0
`define TLIC_LEVEL_LOW_BIT 0
`define TLIC_LEVEL_HIGH_BIT 1
`define TLIC_LEVEL_REQ_BIT 2

// Vector addresses
`define TLIC_VEC_W 16
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_TMR0 16'h000b
`define TLIC_VEC_EXT1 16'h0013
`define TLIC_VEC_TMR1 16'h001b
`define TLIC_VEC_SER 16'h002b
`define TLIC_VEC_BLANK 16'h0033

// Reset values
`define TLIC_RST_BYTE 8'h00
`define TLIC_RST_SRC 6'h00
`define TLIC_RST_VEC 16'h0000

`endif

//--- tlic_pkg.sv
`default_nettype none
`include "tlic_defines.svh"

package tlic_pkg;

    typedef enum logic [1:0] {
        TLIC_ST_IDLE = 2'b00,
        TLIC_ST_OFFER = 2'b01,
        TLIC_ST_ACKED = 2'b11
    } tlic_phase_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic evt;
    } tlic_sense_t;

    typedef struct packed {
        logic prevH;
        logic prevV;
        logic evt;
    } tlic_blank_t;

    typedef struct packed {
        logic [`TLIC_DATA_W-1:0] ie;
        logic [`TLIC_NSRC-1:0] ip;
        logic sense0;
        logic sense1;
        logic textMode;
        logic idle;
        logic [`TLIC_NSRC-1:0] status;
        logic [`TLIC_NSRC-1:0] mask;
        logic [`TLIC_NSRC-1:0] pend;
        logic inSvcLow;
        logic inSvcHigh;
        tlic_phase_t phase;
        logic [`TLIC_SRC_W-1:0] src;
        logic [`TLIC_VEC_W-1:0] vec;
        logic [`TLIC_DATA_W-1:0] rdata;
    } tlic_state_t;

    typedef struct packed {
        logic [`TLIC_ADDR_W-1:0] addr;
        logic [`TLIC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tlic_bus_t;

endpackage : tlic_pkg

`default_nettype wire

//--- tlic_ext_sense.sv
`timescale 1ns/100ps
`default_nettype none

module tlic_ext_sense
    import tlic_pkg::*;
#(
    parameter bit BOTH_EDGES = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and mode
    input wire logic pinAsync,
    input wire logic senseEdge,
    // Requests
    output logic levelReq,
    output logic edgeEvt
);

    tlic_sense_t stateFf;
    tlic_sense_t nxt_state;

    always_comb begin
        nxt_state = stateFf;
        nxt_state.sync1 = pinAsync;
        nxt_state.sync2 = stateFf.sync1;
        nxt_state.prev = stateFf.sync2;
        // Falling edge on either pin in edge mode; rising edge too on the two-edge pin
        nxt_state.evt = senseEdge && ((stateFf.prev && !stateFf.sync2) ||
                        (BOTH_EDGES && !stateFf.prev && stateFf.sync2));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateFf <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, evt: 1'b0};
        end else begin
            stateFf <= nxt_state;
        end
    end

    assign levelReq = !senseEdge && !stateFf.sync2;
    assign edgeEvt = stateFf.evt;

endmodule : tlic_ext_sense

`default_nettype wire

//--- tlic_blank_det.sv
`timescale 1ns/100ps
`default_nettype none

module tlic_blank_det
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Display timing
    input wire logic hBlank,
    input wire logic vBlank,
    input wire logic lineActive,
    input wire logic textMode,
    // Event
    output logic blankEvt
);

    tlic_blank_t stateFf;
    tlic_blank_t nxt_state;

    always_comb begin
        nxt_state = stateFf;
        nxt_state.prevH = hBlank;
        nxt_state.prevV = vBlank;
        if (textMode) begin
            nxt_state.evt = hBlank && !stateFf.prevH && lineActive;
        end else begin
            nxt_state.evt = vBlank && !stateFf.prevV;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxt_state;
        end
    end

    assign blankEvt = stateFf.evt;

endmodule : tlic_blank_det

`default_nettype wire

//--- tlic_top_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "tlic_defines.svh"
module tlic_top_props
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [`TLIC_ADDR_W-1:0] regAddr,
    input wire logic [`TLIC_DATA_W-1:0] regWdata,
    input wire logic regWr,
    // Sources
    input wire logic serialBusEvt,
    input wire logic hBlank,
    input wire logic vBlank,
    input wire logic lineActive,
    // Core side
    input wire logic irqReq,
    input wire logic [`TLIC_VEC_W-1:0] irqVector,
    input wire logic irqAck,
    input wire logic idleMode,
    input wire logic irqLine
);
    logic [7:0] ieSh_ff;
    logic [7:0] maskSh_ff;
    logic textSh_ff;

    // Shadows of the registers the properties depend on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ieSh_ff <= 8'h00;
            maskSh_ff <= 8'h00;
            textSh_ff <= 1'b0;
        end else if (regWr) begin
            if (regAddr == `TLIC_ADDR_IE) ieSh_ff <= regWdata;
            if (regAddr == `TLIC_ADDR_MASK) maskSh_ff <= regWdata;
            if (regAddr == `TLIC_ADDR_CFG) textSh_ff <= regWdata[0];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_vecLegal;
        irqReq |-> irqVector inside {`TLIC_VEC_EXT0, `TLIC_VEC_TMR0, `TLIC_VEC_EXT1,
            `TLIC_VEC_TMR1, `TLIC_VEC_SER, `TLIC_VEC_BLANK};
    endproperty
    a_vecLegal: assert property (p_vecLegal) else $error("offered vector not in table");
    property p_ackGap;
        irqReq && irqAck |=> !irqReq [*2];
    endproperty
    a_ackGap: assert property (p_ackGap) else $error("offer back too soon after ack");
    property p_globalOff;
        !ieSh_ff[7] && !$past(ieSh_ff[7]) |-> !irqReq;
    endproperty
    a_globalOff: assert property (p_globalOff) else $error("offer with global enable clear");
    property p_srcEnable;
        $rose(irqReq) && irqVector == `TLIC_VEC_TMR0 |-> ieSh_ff[1] && ieSh_ff[7];
    endproperty
    a_srcEnable: assert property (p_srcEnable) else $error("disabled source offered");
    property p_idleWake;
        $rose(irqReq) |-> ##[0:1] !idleMode;
    endproperty
    a_idleWake: assert property (p_idleWake) else $error("idle stays set on request");
    property p_textBlank;
        $rose(hBlank) && lineActive && textSh_ff && maskSh_ff[5] |-> ##[1:4] irqLine;
    endproperty
    a_textBlank: assert property (p_textBlank) else $error("no line blank event");
    property p_vertBlank;
        $rose(vBlank) && !textSh_ff && maskSh_ff[5] |-> ##[1:4] irqLine;
    endproperty
    a_vertBlank: assert property (p_vertBlank) else $error("no field blank event");
    property p_serLine;
        serialBusEvt && maskSh_ff[4] |-> ##[1:2] irqLine;
    endproperty
    a_serLine: assert property (p_serLine) else $error("line low after unmasked event");
endmodule : tlic_top_props
`default_nettype wire

//--- tlic_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    input wire logic irqReq,
    input wire logic [15:0] irqVector,
    output logic irqAck,
    output logic irqReturn,
    // Bench control
    input wire logic ackEn,
    input wire logic [3:0] ackDelay,
    input wire logic retCmd,
    output logic [15:0] takenVec,
    output logic [7:0] takenCnt
);
    logic [3:0] waitCnt_ff;

    // Ack after a set wait; the vector counts only at the sampling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqAck <= 1'b0;
            irqReturn <= 1'b0;
            takenVec <= 16'h0000;
            takenCnt <= 8'h00;
            waitCnt_ff <= 4'h0;
        end else begin
            irqAck <= 1'b0;
            irqReturn <= retCmd;
            waitCnt_ff <= 4'h0;
            if (irqReq && !irqAck && ackEn) begin
                if (waitCnt_ff >= ackDelay) begin
                    irqAck <= 1'b1;
                end else begin
                    waitCnt_ff <= waitCnt_ff + 4'h1;
                end
            end
            if (irqReq && irqAck) begin
                takenVec <= irqVector;
                takenCnt <= takenCnt + 8'h01;
            end
        end
    end
endmodule : tlic_core_model
`default_nettype wire

//--- tlic_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "tlic_defines.svh"
module tlic_top_tb
    import tlic_pkg::*;
;
    logic clk, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, extPin0 = 1'b1, extPin1 = 1'b1;
    logic tmrOvf0 = 1'b0, tmrOvf1 = 1'b0, serialBusEvt = 1'b0, hBlank = 1'b0, vBlank = 1'b0;
    logic lineActive = 1'b0, ackEn = 1'b1, retCmd = 1'b0;
    logic [3:0] ackDelay = 4'h3;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata, takenCnt;
    logic [15:0] irqVector, takenVec;
    logic irqReq, irqAck, irqReturn, idleMode, irqLine;
    int bad_count = 0;
    int comparisons = 0;

    tlic_top tlic_top_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .extPin0(extPin0), .extPin1(extPin1), .tmrOvf0(tmrOvf0),
        .tmrOvf1(tmrOvf1), .serialBusEvt(serialBusEvt), .hBlank(hBlank), .vBlank(vBlank),
        .lineActive(lineActive), .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck),
        .irqReturn(irqReturn), .idleMode(idleMode), .irqLine(irqLine));
    tlic_core_model tlic_core_model_i (.clk(clk), .rst(rst), .irqReq(irqReq), .irqVector(irqVector),
        .irqAck(irqAck), .irqReturn(irqReturn), .ackEn(ackEn), .ackDelay(ackDelay), .retCmd(retCmd),
        .takenVec(takenVec), .takenCnt(takenCnt));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk({8'h00, regRdata}, {8'h00, e});
    endtask : rd

    task automatic pulse(input logic [2:0] v);
        @(posedge clk);
        {tmrOvf0, tmrOvf1, serialBusEvt} <= v;
        @(posedge clk);
        {tmrOvf0, tmrOvf1, serialBusEvt} <= 3'b000;
    endtask : pulse

    task automatic pins(input logic a, input logic b);
        @(posedge clk);
        extPin0 <= a;
        extPin1 <= b;
    endtask : pins

    task automatic disp(input logic h, input logic v, input logic l);
        @(posedge clk);
        {hBlank, vBlank, lineActive} <= {h, v, l};
    endtask : disp

    task automatic take(input logic [15:0] exp);
        logic [7:0] c0;
        #1;
        c0 = takenCnt;
        for (int i = 0; i < 60 && takenCnt == c0; i++) @(posedge clk);
        #1;
        chk(takenVec, exp);
        chk({8'h00, takenCnt}, {8'h00, c0 + 8'h01});
    endtask : take

    task automatic none();
        logic [7:0] c0;
        #1;
        c0 = takenCnt;
        repeat (15) @(posedge clk);
        #1;
        chk({8'h00, takenCnt}, {8'h00, c0});
    endtask : none

    task automatic ret();
        @(posedge clk);
        retCmd <= 1'b1;
        @(posedge clk);
        retCmd <= 1'b0;
    endtask : ret

    task automatic lineIs(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, irqLine}, {15'h0000, e});
    endtask : lineIs

    task automatic doReset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (15) @(posedge clk);
        rst <= 1'b0;
    endtask : doReset

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        doReset();
        wr(16'h0010, 8'hff);
        for (int a = 0; a < 8; a++) rd(16'(a), 8'h00);
        rd(`TLIC_ADDR_CFG, 8'h00);
        rd(16'h0010, 8'h00);
        // Polling order, slow acks, wake from idle
        wr(`TLIC_ADDR_IE, 8'hbf);
        wr(`TLIC_ADDR_MASK, 8'h3f);
        wr(`TLIC_ADDR_IDLE, 8'h01);
        rd(`TLIC_ADDR_IDLE, 8'h01);
        ackEn <= 1'b0;
        pulse(3'b111);
        // Offer stands unacknowledged: offer flag and vector low byte
        rd(`TLIC_ADDR_LEVEL, 8'h04);
        rd(`TLIC_ADDR_VECLO, 8'h0b);
        ackEn <= 1'b1;
        take(`TLIC_VEC_TMR0);
        chk({15'h0000, idleMode}, 16'h0000);
        ret();
        take(`TLIC_VEC_TMR1);
        ret();
        take(`TLIC_VEC_SER);
        ret();
        ackDelay <= 4'h0;
        // Edge sensing
        wr(`TLIC_ADDR_TCTL, 8'h03);
        pins(1'b0, 1'b1);
        take(`TLIC_VEC_EXT0);
        ret();
        pins(1'b0, 1'b0);
        take(`TLIC_VEC_EXT1);
        ret();
        pins(1'b0, 1'b1);
        take(`TLIC_VEC_EXT1);
        ret();
        pins(1'b1, 1'b1);
        none();
        // Level sensing
        wr(`TLIC_ADDR_TCTL, 8'h00);
        pins(1'b0, 1'b1);
        take(`TLIC_VEC_EXT0);
        ret();
        take(`TLIC_VEC_EXT0);
        pins(1'b1, 1'b1);
        none();
        ret();
        none();
        // Display blanking in both modes; status cleared before each mode's offers are checked
        wr(`TLIC_ADDR_CFG, 8'h01);
        wr(`TLIC_ADDR_STATUS, 8'h3f);
        disp(1'b0, 1'b0, 1'b1);
        disp(1'b1, 1'b0, 1'b1);
        take(`TLIC_VEC_BLANK);
        ret();
        disp(1'b0, 1'b0, 1'b0);
        disp(1'b1, 1'b0, 1'b0);
        none();
        wr(`TLIC_ADDR_CFG, 8'h00);
        wr(`TLIC_ADDR_STATUS, 8'h3f);
        disp(1'b0, 1'b0, 1'b0);
        disp(1'b0, 1'b1, 1'b0);
        take(`TLIC_VEC_BLANK);
        ret();
        disp(1'b0, 1'b0, 1'b1);
        disp(1'b1, 1'b0, 1'b1);
        none();
        disp(1'b0, 1'b0, 1'b0);
        // Two levels and nesting
        wr(`TLIC_ADDR_IP, 8'h08);
        ackEn <= 1'b0;
        pulse(3'b110);
        ackEn <= 1'b1;
        take(`TLIC_VEC_TMR1);
        rd(`TLIC_ADDR_LEVEL, 8'h02);
        pulse(3'b100);
        none();
        ret();
        take(`TLIC_VEC_TMR0);
        pulse(3'b010);
        take(`TLIC_VEC_TMR1);
        rd(`TLIC_ADDR_LEVEL, 8'h03);
        ret();
        pulse(3'b001);
        none();
        ret();
        take(`TLIC_VEC_SER);
        ret();
        rd(`TLIC_ADDR_LEVEL, 8'h00);
        // Status, mask and the line, then enables
        doReset();
        wr(`TLIC_ADDR_MASK, 8'h10);
        rd(`TLIC_ADDR_MASK, 8'h10);
        pulse(3'b001);
        lineIs(1'b1);
        rd(`TLIC_ADDR_STATUS, 8'h10);
        wr(`TLIC_ADDR_STATUS, 8'h10);
        lineIs(1'b0);
        wr(`TLIC_ADDR_MASK, 8'h00);
        pulse(3'b010);
        lineIs(1'b0);
        rd(`TLIC_ADDR_STATUS, 8'h08);
        wr(`TLIC_ADDR_IE, 8'h02);
        pulse(3'b100);
        none();
        wr(`TLIC_ADDR_IE, 8'h80);
        pulse(3'b100);
        none();
        tally_and_finish();
    end
endmodule : tlic_top_tb

bind tlic_top tlic_top_props tlic_top_props_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .serialBusEvt(serialBusEvt), .hBlank(hBlank), .vBlank(vBlank),
    .lineActive(lineActive), .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck),
    .idleMode(idleMode), .irqLine(irqLine));
`default_nettype wire
